// *** src/adc_link_defines.vh ***
// Constants for the converter link strap decoder and framer.
// Assumes inclusion by its bare name from the design file.
`ifndef ADC_LINK_DEFINES_VH
`define ADC_LINK_DEFINES_VH
// Register offsets on the plain register port
`define REG_CTRL        2'h0
`define REG_STATUS      2'h1
// Control register fields
`define CTRL_EST_POWER  0
`define CTRL_GAIN_6DB   1
`define CTRL_FRAME_ALIGN_REPLACE     2
`define CTRL_SYNC_CHAR  3
`define CTRL_SERIAL_SEL 4
`define CTRL_SCRAMBLE   5
`define CTRL_TEST_LO    6
`define CTRL_TEST_HI    7
`define CTRL_RESET      8'h00
// Mode pin level codes, lowest to highest
`define MODE_SERIAL     2'h0
`define MODE_PARALLEL   2'h2
// Link characters
`define CHAR_K28_5      8'hBC
`define CHAR_K28_7      8'hFC
`define CHAR_D5_6       8'hC5
`define CHAR_D16_2      8'h50
// Test encoder words
`define TEST_WORD_01    16'hB5B5
`define TEST_WORD_10    16'hFF00
`define PRBS_SEED       15'h7FFF
`define SCR_SEED        15'h7FFF
// Sync characters kept after the request is released
`define SYNC_TAIL       4'h4
`define FIFO_DEPTH      8
`endif

// *** src/adc_link_pin_config.v ***
// Strap decode, test-pattern select, gain and lane framing for the converter link.
// Assumes strap and mode pins arrive as 2-bit level codes from comparators,
// sync request and pins are asynchronous, samples come from the clk_in domain.
//
// Summary of operation
// [R1] Serial mode: estimate outputs follow register choice
// [R2] Parallel mode at 5/8 level; early estimate only
// [R3] Alignment strap levels decode to align/sync bits
// [R4] Lane strap levels decode to lane/scramble bits
// [R5] Repeated last octet becomes K28.7 if enabled
// [R6] Sync select 0 sends K28.5 during sync
// [R7] Sync select 1 alternates K28.5 with D5.6/D16.2
// [R8] Select 0: two octets per frame, one lane
// [R9] Select 1: one octet per frame, two lanes
// [R10] Scrambler bypassed or applied per enable bit
// [R11] Parallel mode: serial data pins select tests
// [R12] Gain resets to zero decibels
// [R13] Test bits pick samples, B5B5, FF00 or PRBS
// [R14] Reset held high by outside in parallel mode
// [R15] Receiver requests sync through request input
// [R16] Straps latched, applied at next resync
`timescale 1ns/1ps
`include "adc_link_defines.vh"

// Small flip-flop FIFO; ready and valid are registered.
module link_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_in,
  input  wire             rstn_in,
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output reg              in_ready_out,
  output wire [WIDTH-1:0] out_data_out,
  output reg              out_valid_out,
  input  wire             out_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0]    wptr;            // Write index
  reg [AW-1:0]    rptr;            // Read index
  reg [AW:0]      count;           // Words held
  wire            push = in_valid_in & in_ready_out;
  wire            pop  = out_valid_out & out_ready_in;
  wire [AW:0]     next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data_out = mem[rptr];

  // Pointer and flag update; flags derive from the next count so they stay honest
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wptr          <= {AW{1'b0}};
      rptr          <= {AW{1'b0}};
      count         <= {(AW+1){1'b0}};
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        mem[wptr] <= in_data_in;
        wptr      <= (wptr == DEPTH - 1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == DEPTH - 1) ? {AW{1'b0}} : rptr + 1'b1;
      end
      count         <= next_count;
      in_ready_out  <= (next_count != DEPTH);
      out_valid_out <= (next_count != 0);
    end
  end
endmodule

module adc_link_pin_config #(
  parameter FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire        clk_in,
  input  wire        rstn_in,
  input  wire [1:0]  mode_level_in,
  input  wire [1:0]  align_sync_strap_pin_in,
  input  wire [1:0]  lane_scramble_strap_pin_in,
  input  wire        test_select_low_pin_in,
  input  wire        test_select_high_pin_in,
  input  wire        sync_req_n_in,
  input  wire [3:0]  early_estimate_in,
  input  wire [3:0]  power_estimate_in,
  input  wire [13:0] sample_in,
  input  wire        sample_valid_in,
  output wire        sample_ready_out,
  input  wire [1:0]  addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [7:0]  rdata_out,
  output reg  [3:0]  estimate_out,
  output reg  [7:0]  lane0_data_out,
  output reg         lane0_k_out,
  output reg  [7:0]  lane1_data_out,
  output reg         lane1_k_out,
  output reg         lane_valid_out,
  output reg         serialization_select_out
);
  // Framer states, one-hot
  localparam ST_SYNC = 3'b001;
  localparam ST_TAIL = 3'b010;
  localparam ST_DATA = 3'b100;

  // Level code to setting pair {first, second}: 0->00, 1->10, 2->11, 3->01
  function [1:0] strap_decode;
    input [1:0] lvl;
    begin
      strap_decode = {lvl[0] ^ lvl[1], lvl[1]};
    end
  endfunction

  // 1+x^14+x^15 self-synchronous scrambler over one octet, msb first
  function [22:0] scramble_octet;
    input [14:0] st;
    input [7:0]  d;
    reg   [14:0] s;
    reg   [7:0]  q;
    integer      i;
    begin
      s = st;
      q = 8'h00;
      for (i = 7; i >= 0; i = i - 1) begin
        q[i] = d[i] ^ s[14] ^ s[13];
        s    = {s[13:0], q[i]};
      end
      scramble_octet = {s, q};
    end
  endfunction

  // Two-flop synchronisers for pins and the sync request
  reg [9:0] pin_s1;                // First stage, read only by second
  reg [9:0] pin_s2;                // Second stage, safe to use
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_s1 <= 10'h001;
      pin_s2 <= 10'h001;
    end else begin
      pin_s1 <= {mode_level_in, align_sync_strap_pin_in, lane_scramble_strap_pin_in,
                 test_select_high_pin_in, test_select_low_pin_in, 1'b0, sync_req_n_in};
      pin_s2 <= pin_s1;
    end
  end
  wire [1:0] mode_lvl   = pin_s2[9:8];
  wire       parallel   = (mode_lvl == `MODE_PARALLEL);              // [R2]
  wire       mode_fault = mode_lvl[0];                               // Levels 1, 3 misuse
  wire       sync_req   = ~pin_s2[0];                                // [R15]

  // Control register; writes land at every mode level but parallel, pins are straps otherwise
  reg [7:0] ctrl;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= `CTRL_RESET;                                           // [R12]
    end else if (wr_in && !parallel && addr_in == `REG_CTRL) begin   // [R11]
      ctrl <= wdata_in;
    end
  end

  // Live settings: straps in parallel mode, register fields in serial mode
  wire [1:0] align_pair = strap_decode(pin_s2[7:6]);                 // [R3]
  wire [1:0] lane_pair  = strap_decode(pin_s2[5:4]);                 // [R4]
  wire [3:0] live_cfg   = parallel ? {align_pair, lane_pair} : ctrl[5:2];
  wire [1:0] test_sel   = parallel ? pin_s2[3:2] : ctrl[7:6];        // [R11]

  // Latched link settings {frame_align_replace, sync_char, serial_sel, scramble}
  reg  [3:0] link_cfg;
  reg        cfg_loaded;                                             // First load after reset
  wire       frame_align_replace  = link_cfg[3];
  wire       sync_char_select     = link_cfg[2];
  wire       serialization_select = link_cfg[1];
  wire       scramble_enable      = link_cfg[0];

  // Sample path: gain, then encoder input select
  reg  [14:0] prbs;                                                  // Test sequence state
  wire [15:0] raw    = {sample_in, 2'b00};
  wire [15:0] gained = (ctrl[`CTRL_GAIN_6DB] && !parallel) ?
                       ((raw[15] != raw[14]) ? {raw[15], {15{~raw[15]}}} : {raw[14:0], 1'b0})
                       : raw;                                        // [R12]
  wire [22:0] prbs_hi = scramble_octet(prbs, 8'h00);
  wire [22:0] prbs_lo = scramble_octet(prbs_hi[22:8], 8'h00);
  reg  [15:0] enc_word;
  // Test pattern mux; top bit tags PRBS words so the scrambler skips them
  always @* begin
    case (test_sel)                                                  // [R13]
      2'b01:   enc_word = `TEST_WORD_01;
      2'b10:   enc_word = `TEST_WORD_10;
      2'b11:   enc_word = {prbs_hi[7:0], prbs_lo[7:0]};
      default: enc_word = gained;
    endcase
  end
  wire fifo_push = sample_valid_in & sample_ready_out;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prbs <= `PRBS_SEED;
    end else if (fifo_push && test_sel == 2'b11) begin
      prbs <= prbs_lo[22:8];
    end
  end

  wire [16:0] fifo_word;
  wire        fifo_valid;
  reg         fifo_pop;
  link_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_data_in    ({test_sel == 2'b11, enc_word}),
    .in_valid_in   (sample_valid_in),
    .in_ready_out  (sample_ready_out),
    .out_data_out  (fifo_word),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop)
  );

  // Framer state
  reg [2:0]  state;
  reg [3:0]  tail_cnt;                                               // Sync chars left after release
  reg        alt;                                                    // K28.5 / data char toggle
  reg        alt_idx;                                                // D5.6 or D16.2 next
  reg        phase;                                                  // Second octet pending
  reg [7:0]  low_hold;                                               // Second octet of the frame
  reg        hold_prbs;
  reg [14:0] scr0;
  reg [14:0] scr1;
  reg [7:0]  last0;                                                  // Last octet, previous frame
  reg [7:0]  last1;

  wire [22:0] s_hi = scramble_octet(scr0, fifo_word[15:8]);
  wire [22:0] s_lo = scramble_octet(serialization_select ? scr1 : s_hi[22:8],
                                    fifo_word[7:0]);                 // [R10]
  wire        bypass   = ~scramble_enable | fifo_word[16];           // [R13]
  wire [7:0]  oct_hi   = bypass ? fifo_word[15:8] : s_hi[7:0];
  wire [7:0]  oct_lo   = bypass ? fifo_word[7:0]  : s_lo[7:0];
  wire [7:0]  sync_chr = (!sync_char_select || !alt) ? `CHAR_K28_5 :
                         (alt_idx ? `CHAR_D16_2 : `CHAR_D5_6);       // [R6] [R7]
  wire        sync_k   = !sync_char_select || !alt;

  always @* begin
    fifo_pop = (state == ST_DATA) && fifo_valid && !phase;
  end

  // Framer: sync characters, then frames of data octets
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state          <= ST_SYNC;
      tail_cnt       <= 4'h0;
      alt            <= 1'b0;
      alt_idx        <= 1'b0;
      phase          <= 1'b0;
      low_hold       <= 8'h00;
      hold_prbs      <= 1'b0;
      scr0           <= `SCR_SEED;
      scr1           <= `SCR_SEED;
      last0          <= 8'h00;
      last1          <= 8'h00;
      link_cfg       <= 4'h0;
      cfg_loaded     <= 1'b0;
      lane0_data_out <= 8'h00;
      lane0_k_out    <= 1'b0;
      lane1_data_out <= 8'h00;
      lane1_k_out    <= 1'b0;
      lane_valid_out <= 1'b0;
      serialization_select_out <= 1'b0;
    end else begin
      lane_valid_out <= 1'b0;
      if (!cfg_loaded) begin
        link_cfg   <= live_cfg;                                      // [R16]
        cfg_loaded <= 1'b1;
      end
      serialization_select_out <= serialization_select;
      case (state)
        ST_SYNC: begin
          // Settings change only here, while the receiver resynchronises
          link_cfg       <= live_cfg;                                // [R16]
          lane0_data_out <= sync_chr;
          lane0_k_out    <= sync_k;
          lane1_data_out <= sync_chr;
          lane1_k_out    <= sync_k;
          lane_valid_out <= 1'b1;
          alt            <= ~alt;
          alt_idx        <= alt ? ~alt_idx : alt_idx;
          phase          <= 1'b0;
          if (!sync_req) begin
            state    <= ST_TAIL;
            tail_cnt <= `SYNC_TAIL;
          end
        end
        ST_TAIL: begin
          // Keep sync characters briefly after release
          lane0_data_out <= sync_chr;
          lane0_k_out    <= sync_k;
          lane1_data_out <= sync_chr;
          lane1_k_out    <= sync_k;
          lane_valid_out <= 1'b1;
          alt            <= ~alt;
          alt_idx        <= alt ? ~alt_idx : alt_idx;
          tail_cnt       <= tail_cnt - 4'h1;
          if (sync_req) begin
            state <= ST_SYNC;
          end else if (tail_cnt == 4'h1) begin
            state <= ST_DATA;
            alt   <= 1'b0;
          end
        end
        ST_DATA: begin
          if (sync_req && !phase) begin
            state <= ST_SYNC;
          end else if (phase) begin
            // Single lane, second octet closes the frame
            lane0_data_out <= (frame_align_replace && low_hold == last0) ?
                              `CHAR_K28_7 : low_hold;                // [R5]
            lane0_k_out    <= frame_align_replace && low_hold == last0;
            last0          <= low_hold;
            lane_valid_out <= 1'b1;
            phase          <= 1'b0;
          end else if (fifo_valid) begin
            if (!fifo_word[16] && scramble_enable) begin
              scr0 <= serialization_select ? s_hi[22:8] : s_lo[22:8];
              scr1 <= s_lo[22:8];
            end
            lane_valid_out <= 1'b1;
            if (serialization_select) begin
              // Two lanes, one octet per lane per frame                    [R9]
              lane0_data_out <= (frame_align_replace && oct_hi == last0) ?
                                `CHAR_K28_7 : oct_hi;                // [R5]
              lane0_k_out    <= frame_align_replace && oct_hi == last0;
              lane1_data_out <= (frame_align_replace && oct_lo == last1) ?
                                `CHAR_K28_7 : oct_lo;                // [R5]
              lane1_k_out    <= frame_align_replace && oct_lo == last1;
              last0          <= oct_hi;
              last1          <= oct_lo;
            end else begin
              // One lane, two octets per frame                             [R8]
              lane0_data_out <= oct_hi;
              lane0_k_out    <= 1'b0;
              lane1_data_out <= 8'h00;
              lane1_k_out    <= 1'b0;
              low_hold       <= oct_lo;
              hold_prbs      <= fifo_word[16];
              phase          <= 1'b1;
            end
          end
        end
        default: state <= ST_SYNC;
      endcase
    end
  end

  // Estimate routing and register reads, one cycle after the strobe
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      estimate_out <= 4'h0;
      rdata_out    <= 8'h00;
    end else begin
      estimate_out <= (!parallel && ctrl[`CTRL_EST_POWER]) ?
                      power_estimate_in : early_estimate_in;         // [R1] [R2]
      if (rd_in && addr_in == `REG_CTRL) begin
        rdata_out <= ctrl;
      end else if (rd_in && addr_in == `REG_STATUS) begin
        rdata_out <= {link_cfg, parallel, mode_fault, state == ST_DATA, sync_req};
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end
endmodule

// *** testbench/adc_link_pin_config_chk.sv ***
// Checker for the converter link block: estimate routing, sync characters, strap latch.
// Assumes it is bound to adc_link_pin_config and sees only that module's ports.
`timescale 1ns/1ps
`include "adc_link_defines.vh"
module adc_link_pin_config_chk (
  input wire       clk_in,
  input wire       rstn_in,
  input wire [1:0] mode_level_in,
  input wire [1:0] align_sync_strap_pin_in,
  input wire [1:0] lane_scramble_strap_pin_in,
  input wire       sync_req_n_in,
  input wire [3:0] early_estimate_in,
  input wire [3:0] power_estimate_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire [3:0] estimate_out,
  input wire [7:0] lane0_data_out,
  input wire       lane0_k_out,
  input wire [7:0] lane1_data_out,
  input wire       lane1_k_out,
  input wire       lane_valid_out,
  input wire       serialization_select_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Parallel mode, request held and straps steady long enough to be latched
  sequence s_par_sync;
    (mode_level_in == 2'h2 && !sync_req_n_in && $stable(align_sync_strap_pin_in)
     && $stable(lane_scramble_strap_pin_in))[*8];
  endsequence
  // One character of the alternating sync kind
  sequence s_alt_char;
    lane_valid_out && (lane0_k_out ? lane0_data_out == `CHAR_K28_5 :
      (lane0_data_out == `CHAR_D5_6 || lane0_data_out == `CHAR_D16_2));
  endsequence
  est_parallel_a: assert property ((mode_level_in == 2'h2)[*4] |=>
    estimate_out == $past(early_estimate_in)) else $error("estimate not early");
  est_serial_a: assert property ((mode_level_in == 2'h0)[*4] |=>
    estimate_out == $past(early_estimate_in) || estimate_out == $past(power_estimate_in))
    else $error("estimate from no source");
  read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  sync_comma_a: assert property (s_par_sync ##0 !align_sync_strap_pin_in[1] |->
    lane_valid_out && lane0_k_out && lane0_data_out == `CHAR_K28_5)
    else $error("sync char not comma");
  sync_alternate_a: assert property (s_par_sync ##0 align_sync_strap_pin_in[1] |->
    s_alt_char ##1 (lane0_k_out != $past(lane0_k_out))) else $error("no alternation");
  lane_pair_a: assert property (s_par_sync |-> lane1_data_out == lane0_data_out
    && lane1_k_out == lane0_k_out) else $error("lanes differ in sync");
  lane_select_a: assert property (s_par_sync |->
    serialization_select_out == ^lane_scramble_strap_pin_in) else $error("lane select");
  strap_hold_a: assert property (sync_req_n_in[*8] ##1 sync_req_n_in |=>
    $stable(serialization_select_out)) else $error("lane select moved outside sync");
endmodule
bind adc_link_pin_config adc_link_pin_config_chk i_chk (.clk_in, .rstn_in, .mode_level_in,
  .align_sync_strap_pin_in, .lane_scramble_strap_pin_in, .sync_req_n_in,
  .early_estimate_in, .power_estimate_in, .rd_in, .rdata_out, .estimate_out,
  .lane0_data_out, .lane0_k_out, .lane1_data_out, .lane1_k_out, .lane_valid_out,
  .serialization_select_out);

// *** testbench/link_rx_model.sv ***
// Link receiver model: raises sync requests and counts received commas.
// Assumes the lanes come from the block under test in the same clock domain.
`timescale 1ns/1ps
module link_rx_model (
  input  wire       clk_in,
  input  wire [7:0] lane0_data_in,
  input  wire       lane0_k_in,
  input  wire       lane_valid_in,
  output reg        sync_req_n_out
);
  integer n_comma; // Commas seen so far
  // Idle receiver does not request sync
  initial begin
    sync_req_n_out = 1'b1;
    n_comma = 0;
  end
  // Count commas, so the bench can see that a request got an answer
  always @(posedge clk_in) begin
    if (lane_valid_in && lane0_k_in && lane0_data_in == 8'hBC) begin
      n_comma <= n_comma + 1;
    end
  end
  // Hold the request low for n cycles; a long n models a slow receiver
  task request_sync(input integer n);
    sync_req_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    sync_req_n_out <= 1'b1;
  endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the strap decoder and lane framer.
// Assumes the checker is bound in and the receiver model sits on the sync input.
`timescale 1ns/1ps
`include "adc_link_defines.vh"
module testbench;
  reg        clk_in, rstn_in, test_select_low_pin_in, test_select_high_pin_in;
  reg        sample_valid_in, wr_in, rd_in, rd_q, refused;
  reg [1:0]  mode_level_in, align_sync_strap_pin_in, lane_scramble_strap_pin_in, addr_in;
  reg [3:0]  early_estimate_in, power_estimate_in;
  reg [13:0] sample_in;
  reg [7:0]  wdata_in;
  wire       sync_req_n_in, sample_ready_out, lane0_k_out, lane1_k_out, lane_valid_out;
  wire       serialization_select_out;
  wire [7:0] rdata_out, lane0_data_out, lane1_data_out;
  wire [3:0] estimate_out;
  integer    n_errors, checked, seed, i, r, c0;
  reg        scr_on;  // Scrambled scenario active
  reg [14:0] sst;     // Bench scrambler state, starts at the seed like the lane
  logic [15:0] rq[$]; // Pending reads: mask, value
  logic [17:0] lq[$]; // Pending octets: k0, lane0, k1, lane1
  adc_link_pin_config i_adc_link_pin_config (.clk_in, .rstn_in, .mode_level_in,
    .align_sync_strap_pin_in, .lane_scramble_strap_pin_in, .test_select_low_pin_in,
    .test_select_high_pin_in, .sync_req_n_in, .early_estimate_in, .power_estimate_in,
    .sample_in, .sample_valid_in, .sample_ready_out, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .estimate_out, .lane0_data_out, .lane0_k_out, .lane1_data_out,
    .lane1_k_out, .lane_valid_out, .serialization_select_out);
  link_rx_model i_link_rx_model (.clk_in, .lane0_data_in(lane0_data_out),
    .lane0_k_in(lane0_k_out), .lane_valid_in(lane_valid_out), .sync_req_n_out(sync_req_n_in));
  // Compare and count
  task check(input logic [17:0] seen, input logic [17:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Register cycles; an idle cycle after each keeps strobes from re-rising in one step
  task wr_reg(input [1:0] a, input [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task rd_reg(input [1:0] a, input [7:0] m, input [7:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    rq.push_back({m, e});
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // Set straps and test pins, then resync so they are taken
  task cfg(input [1:0] a, input [1:0] l, input [1:0] t);
    align_sync_strap_pin_in <= a;
    lane_scramble_strap_pin_in <= l;
    {test_select_high_pin_in, test_select_low_pin_in} <= t;
    @(posedge clk_in);
    c0 = i_link_rx_model.n_comma;
    i_link_rx_model.request_sync(14);
    repeat (16) @(posedge clk_in);
  endtask
  // Push n samples (pairs repeat when fa) and note the octets due on the lanes
  task push(input integer n, input [1:0] t, input fa, input dual, input [13:0] s0);
    reg [15:0] w;
    reg [13:0] s;
    reg [8:0]  last;
    reg [7:0]  prev;
    integer    k;
    integer    b;
    for (k = 0; k < n; k = k + 1) begin
      if (!fa || k % 2 == 0) begin
        r = $random(seed);
        s = (k == 0) ? s0 : r[13:0];
      end
      w = (t == 2'h1) ? `TEST_WORD_01 : (t == 2'h2) ? `TEST_WORD_10 : {s, 2'b00};
      // 1+x^14+x^15, msb first; one lane shares the state over both octets
      for (b = 15; b >= 0 && scr_on; b = b - 1) begin
        w[b] = w[b] ^ sst[14] ^ sst[13];
        sst  = {sst[13:0], w[b]};
      end
      last = (fa && k > 0 && w[7:0] == prev) ? {1'b1, `CHAR_K28_7} : {1'b0, w[7:0]};
      prev = w[7:0];
      if (t != 2'h3 && dual) lq.push_back({1'b0, w[15:8], 1'b0, w[7:0]});
      if (t != 2'h3 && !dual) lq.push_back({1'b0, w[15:8], 9'h000});
      if (t != 2'h3 && !dual) lq.push_back({last, 9'h000});
      sample_in <= s;
      sample_valid_in <= 1'b1;
      @(posedge clk_in);
      while (sample_ready_out !== 1'b1) begin
        refused = 1'b1;
        @(posedge clk_in);
      end
    end
    sample_valid_in <= 1'b0;
    repeat (30) @(posedge clk_in);
    check(lq.size(), 18'h0_0000);
  endtask
  // Result watcher: read data the cycle after the strobe, octets as they leave
  always @(posedge clk_in) begin
    if (rd_q && rq.size() > 0) begin
      check({10'h000, rdata_out & rq[0][15:8]}, {10'h000, rq[0][7:0]});
      rq.delete(0);
    end
    rd_q = rd_in;
    if (lane_valid_out && lq.size() > 0 && !(lane0_k_out && lane0_data_out == `CHAR_K28_5)) begin
      check({lane0_k_out, lane0_data_out, serialization_select_out ? {lane1_k_out,
        lane1_data_out} : lq[0][8:0]}, lq[0]);
      lq.delete(0);
    end
  end
  // Estimate sources change every cycle so a wrong route shows
  always @(posedge clk_in) begin
    early_estimate_in <= $random(seed) & 4'hF;
    power_estimate_in <= $random(seed) & 4'hF;
  end
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // Watchdog, far beyond the fewer than one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors = n_errors + 1;
    conclude;
  end
  initial begin
    {n_errors, checked, rd_q, refused, seed} = {32'd0, 32'd0, 2'b00, 32'd24};
    {scr_on, sst} = {1'b0, `SCR_SEED};
    {rstn_in, mode_level_in, align_sync_strap_pin_in, lane_scramble_strap_pin_in} = 0;
    {test_select_low_pin_in, test_select_high_pin_in, sample_valid_in, wr_in, rd_in} = 0;
    {sample_in, wdata_in, addr_in, early_estimate_in, power_estimate_in} = 0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1; // Held high from here on
    repeat (16) @(posedge clk_in);
    rd_reg(2'h0, 8'hFF, `CTRL_RESET);
    wr_reg(2'h3, 8'h5A);
    rd_reg(2'h3, 8'hFF, 8'h00);
    wr_reg(2'h0, 8'h01);
    rd_reg(2'h0, 8'hFF, 8'h01);
    push(20, 2'h0, 1'b0, 1'b0, 14'h156B);
    check(refused, 18'h0_0001);
    $display("Serial mode defaults done");
    mode_level_in <= `MODE_PARALLEL; // Only the two legal levels are applied
    for (i = 0; i < 4; i = i + 1) begin
      cfg(i[1:0], i[1:0], 2'h0);
      check(i_link_rx_model.n_comma > c0, 18'h0_0001);
      rd_reg(2'h1, 8'hF8, {i[0] ^ i[1], i[1], i[0] ^ i[1], i[1], 4'h8});
    end
    lane_scramble_strap_pin_in <= 2'h0;
    repeat (10) @(posedge clk_in);
    rd_reg(2'h1, 8'hF8, 8'h58);
    wr_reg(2'h0, 8'hFF);
    rd_reg(2'h0, 8'hFF, 8'h01);
    $display("Strap decode done");
    for (i = 0; i < 4; i = i + 1) begin
      cfg(2'h0, 2'h0, i[1:0]);
      push(6, i[1:0], 1'b0, 1'b0, 14'h156B);
    end
    cfg(2'h0, 2'h1, 2'h2);
    push(6, 2'h2, 1'b0, 1'b1, 14'h156B);
    cfg(2'h0, 2'h1, 2'h0);
    push(12, 2'h0, 1'b0, 1'b1, 14'h156B);
    cfg(2'h1, 2'h0, 2'h0);
    push(8, 2'h0, 1'b1, 1'b0, 14'h156B);
    cfg(2'h1, 2'h0, 2'h1);
    push(4, 2'h1, 1'b1, 1'b0, 14'h156B);
    // Lane strap at the top level: one lane with the scrambler on
    cfg(2'h0, 2'h3, 2'h0);
    scr_on = 1'b1;
    push(6, 2'h0, 1'b0, 1'b0, 14'h156B);
    scr_on = 1'b0;
    $display("Lane framing done");
    conclude;
  end
endmodule
